// ---- lcdci_pkg.sv ----
package lcdci_pkg;
  // command opcodes and masks
  localparam logic [7:0] CMD_TEXT_HOME = 8'h40;
  localparam logic [7:0] CMD_TEXT_STRIDE = 8'h41;
  localparam logic [7:0] CMD_GFX_HOME = 8'h42;
  localparam logic [7:0] CMD_GFX_STRIDE = 8'h43;
  localparam logic [3:0] GRP_MODE = 4'h8;
  localparam logic [3:0] GRP_DISPLAY = 4'h9;
  // combine function codes in the low three bits
  localparam logic [2:0] MIX_OR = 3'h0;
  localparam logic [2:0] MIX_XOR = 3'h1;
  localparam logic [2:0] MIX_AND = 3'h3;
  localparam logic [2:0] MIX_ATTR = 3'h4;
  // field positions
  localparam int GLYPH_SRC_BIT = 3;
  localparam int ST_EXEC_BIT = 0;
  localparam int ST_RW_BIT = 1;
  localparam int ST_FREE_BIT = 5;
  localparam int EN_BLINK_BIT = 0;
  localparam int EN_CURSOR_BIT = 1;
  localparam int EN_TEXT_BIT = 2;
  localparam int EN_GFX_BIT = 3;
  // glyph split: codes below this come from the builtin store in rom mode
  localparam logic [7:0] USER_CODE_BASE = 8'h80;
  // attribute bits read from the graphic area
  localparam int ATTR_REV_BIT = 0;
  localparam int ATTR_BLINK_BIT = 1;
  localparam int ATTR_INHIBIT_BIT = 2;
  // cycles the device stays busy after a byte
  localparam logic [3:0] BUSY_CYCLES = 4'h3;
  // register bus offsets (word addresses)
  localparam logic [3:0] REG_TX = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_CTRL = 4'h2;
  localparam int CTRL_CMD_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  // reset values
  localparam logic [15:0] HOME_RST = 16'h0000;
  localparam logic [7:0] STRIDE_RST = 8'h00;
endpackage

// ---- lcdci_if.sv ----
`timescale 1ns/1ns
// parallel host port; data bus split into in/out/enable per end
interface lcdci_if;
  logic chip_select_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic cmd_data_select;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  // resolved bus level seen by both ends
  logic [7:0] bus_data;
  assign bus_data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);
  modport host (output chip_select_n, output read_strobe_n, output write_strobe_n,
                output cmd_data_select, output host_data, output host_data_oe, input bus_data);
  modport device (input chip_select_n, input read_strobe_n, input write_strobe_n,
                  input cmd_data_select, output dev_data, output dev_data_oe, input bus_data);
endinterface

// ---- lcdci_device.sv ----
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// How it works
// - host reads status with select, read, cd high
// - status bits 0,1 high only when ready
// - bit 5 undefined, others report state; the device drives bits 2-7 at zero
// - host checks ready before every byte
// - single byte commands, zero to two params
// - params first, execute on command byte
// - 41h/43h set text/graphic row stride
// - 42h sets 16-bit graphic home address
// - 40h sets 16-bit text home address
// - text page starts at text home
// - 6-wide font ignores two upper bits
// - one memory byte per cell line
// - 80h-8Fh low bits choose combine function
// - bit 3 selects builtin or user glyphs
// - pixel is combined text and graphic
// - attribute mode: reverse, blink, inhibit from graphics
// - one combine mode for whole screen
// - host uses only four defined patterns
// - 90h-9Fh enable bits, zero means off; the device uses only the text and graphic bits
// - host holds reset several cycles first
// - rom mode splits codes at 80h
module lcdci_device
  import lcdci_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  lcdci_if.device bus,
  input wire logic font_narrow,
  input wire logic [7:0] text_byte,
  input wire logic [7:0] gfx_byte,
  input wire logic [7:0] char_code,
  input wire logic blink_phase,
  output logic [15:0] text_home,
  output logic [15:0] gfx_home,
  output logic [7:0] text_stride,
  output logic [7:0] gfx_stride,
  output logic [2:0] mix_mode,
  output logic user_glyph_only,
  output logic [3:0] display_enable,
  output logic [7:0] pixel_out,
  output logic glyph_from_rom
);
  logic [7:0] p0_reg, p0_next; // first parameter latched
  logic [7:0] p1_reg, p1_next; // second parameter latched
  logic [1:0] pcnt_reg, pcnt_next; // parameters received since last command
  logic [15:0] th_reg, th_next;
  logic [15:0] gh_reg, gh_next;
  logic [7:0] ts_reg, ts_next;
  logic [7:0] gs_reg, gs_next;
  logic [3:0] mode_reg, mode_next; // bit 3 glyph source, low three combine
  logic [3:0] en_reg, en_next;
  logic [3:0] busy_reg, busy_next; // busy countdown after each byte
  logic wr_d_reg; // previous write strobe qualifier, for edge detect
  logic [7:0] pix_reg, pix_next;
  logic rom_reg, rom_next;
  logic wr_now, wr_edge;
  logic [7:0] status;
  logic [7:0] cmd;

  // a write is taken on the falling edge of the qualified strobe only once
  assign wr_now = !bus.chip_select_n && !bus.write_strobe_n;
  assign wr_edge = wr_now && !wr_d_reg;
  assign cmd = bus.bus_data;

  // status byte: ready flags clear while busy; bit 5 held at zero
  always_comb begin
    status = 8'h00;
    status[ST_EXEC_BIT] = (busy_reg == 4'h0);
    status[ST_RW_BIT] = (busy_reg == 4'h0);
    status[ST_FREE_BIT] = 1'b0;
  end

  // drive status while a status read is in progress
  assign bus.dev_data_oe = !bus.chip_select_n && !bus.read_strobe_n && bus.cmd_data_select;
  assign bus.dev_data = status;

  // command decoder; parameters wait in p0/p1 until the command byte lands
  always_comb begin
    p0_next = p0_reg;
    p1_next = p1_reg;
    pcnt_next = pcnt_reg;
    th_next = th_reg;
    gh_next = gh_reg;
    ts_next = ts_reg;
    gs_next = gs_reg;
    mode_next = mode_reg;
    en_next = en_reg;
    busy_next = (busy_reg != 4'h0) ? busy_reg - 4'h1 : 4'h0;
    if (wr_edge) begin
      busy_next = BUSY_CYCLES;
      if (!bus.cmd_data_select) begin
        // parameter byte: shift into first then second slot
        if (pcnt_reg == 2'h0) begin
          p0_next = cmd;
          pcnt_next = 2'h1;
        end else begin
          // a third parameter overwrites the second; extra bytes are a host fault
          p1_next = cmd;
          pcnt_next = 2'h2;
        end
      end else begin
        pcnt_next = 2'h0;
        case (cmd[7:4])
          4'h4: begin
            case (cmd)
              CMD_TEXT_HOME: th_next = {p1_reg, p0_reg};
              CMD_TEXT_STRIDE: ts_next = p0_reg;
              CMD_GFX_HOME: gh_next = {p1_reg, p0_reg};
              CMD_GFX_STRIDE: gs_next = p0_reg;
              default: ; // other control words are not handled here
            endcase
          end
          GRP_MODE: mode_next = cmd[3:0];
          GRP_DISPLAY: en_next = cmd[3:0];
          default: ; // unsupported opcodes are dropped but still cost a busy period
        endcase
      end
    end
  end

  // pixel merge for the current cell; mode is global, so one path serves the screen
  always_comb begin
    logic [7:0] tb;
    logic [7:0] gb;
    logic [7:0] mask;
    tb = 8'h00;
    gb = 8'h00;
    mask = font_narrow ? 8'h3f : 8'hff;
    tb = en_reg[EN_TEXT_BIT] ? (text_byte & mask) : 8'h00;
    gb = en_reg[EN_GFX_BIT] ? (gfx_byte & mask) : 8'h00;
    case (mode_reg[2:0])
      MIX_OR: pix_next = tb | gb;
      MIX_XOR: pix_next = tb ^ gb;
      MIX_AND: pix_next = tb & gb;
      MIX_ATTR: begin
        // attributes need both areas enabled, else nothing shows
        if (!(en_reg[EN_TEXT_BIT] && en_reg[EN_GFX_BIT])) begin
          pix_next = 8'h00;
        end else if (gfx_byte[ATTR_INHIBIT_BIT]) begin
          pix_next = 8'h00;
        end else if (gfx_byte[ATTR_BLINK_BIT] && blink_phase) begin
          pix_next = 8'h00;
        end else if (gfx_byte[ATTR_REV_BIT]) begin
          pix_next = ~tb & mask;
        end else begin
          pix_next = tb;
        end
      end
      default: pix_next = tb | gb; // undefined patterns fall back to or
    endcase
    // glyph source: user ram only when forced, or for the upper code half
    rom_next = !mode_reg[GLYPH_SRC_BIT] && (char_code < USER_CODE_BASE);
  end

  // state registers
  always_ff @(posedge clk) begin
    if (srst) begin
      p0_reg <= 8'h00;
      p1_reg <= 8'h00;
      pcnt_reg <= 2'h0;
      th_reg <= HOME_RST;
      gh_reg <= HOME_RST;
      ts_reg <= STRIDE_RST;
      gs_reg <= STRIDE_RST;
      mode_reg <= 4'h0;
      en_reg <= 4'h0;
      busy_reg <= 4'h0;
      wr_d_reg <= 1'b0;
      pix_reg <= 8'h00;
      rom_reg <= 1'b0;
    end else begin
      p0_reg <= p0_next;
      p1_reg <= p1_next;
      pcnt_reg <= pcnt_next;
      th_reg <= th_next;
      gh_reg <= gh_next;
      ts_reg <= ts_next;
      gs_reg <= gs_next;
      mode_reg <= mode_next;
      en_reg <= en_next;
      busy_reg <= busy_next;
      wr_d_reg <= wr_now;
      pix_reg <= pix_next;
      rom_reg <= rom_next;
    end
  end

  // the text page origin follows the home register directly, so a rewrite scrolls
  assign text_home = th_reg;
  assign gfx_home = gh_reg;
  assign text_stride = ts_reg;
  assign gfx_stride = gs_reg;
  assign mix_mode = mode_reg[2:0];
  assign user_glyph_only = mode_reg[GLYPH_SRC_BIT];
  assign display_enable = en_reg;
  assign pixel_out = pix_reg;
  assign glyph_from_rom = rom_reg;
endmodule

// ---- lcdci_host.sv ----
`timescale 1ns/1ns
// host end: avalon-mm slave on one side, parallel port master on the other
module lcdci_host
  import lcdci_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  lcdci_if.host bus,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  typedef enum {ST_IDLE, ST_POLL, ST_POLL_CHK, ST_WRITE, ST_WRITE_END} lcdci_state_t;
  lcdci_state_t st_reg, st_next;
  logic [7:0] byte_reg, byte_next; // byte waiting to go out
  logic is_cmd_reg, is_cmd_next; // cd level for that byte
  logic err_reg, err_next; // sticky: write to an offset with nothing behind it
  logic accept_tx;

  // a tx write stalls on waitrequest until the engine is idle
  assign accept_tx = avs_write && (avs_address == REG_TX) && (st_reg == ST_IDLE);
  assign avs_waitrequest = avs_write && (avs_address == REG_TX) && (st_reg != ST_IDLE);

  // engine: poll status before every byte, then strobe it out
  always_comb begin
    st_next = st_reg;
    byte_next = byte_reg;
    is_cmd_next = is_cmd_reg;
    err_next = err_reg;
    case (st_reg)
      ST_IDLE: begin
        if (accept_tx) begin
          byte_next = avs_writedata[7:0];
          is_cmd_next = avs_writedata[CTRL_CMD_BIT];
          st_next = ST_POLL;
        end
      end
      ST_POLL: st_next = ST_POLL_CHK;
      ST_POLL_CHK: begin
        // bit 5 is masked off by looking only at bits 0 and 1
        if (bus.bus_data[ST_EXEC_BIT] && bus.bus_data[ST_RW_BIT]) begin
          st_next = ST_WRITE;
        end else begin
          st_next = ST_POLL;
        end
      end
      ST_WRITE: st_next = ST_WRITE_END;
      ST_WRITE_END: st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
    // software clears the error flag through the control word
    if (avs_write && avs_address == REG_CTRL && avs_writedata[STAT_ERR_BIT]) begin
      err_next = 1'b0;
    end
    // a stray write sets it; tested after the clear so a set in the same cycle wins
    if (avs_write && avs_address != REG_TX && avs_address != REG_CTRL) begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= ST_IDLE;
      byte_reg <= 8'h00;
      is_cmd_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      byte_reg <= byte_next;
      is_cmd_reg <= is_cmd_next;
      err_reg <= err_next;
    end
  end

  // read data is combinational from current state so it stands at the accepting edge
  always_comb begin
    case (avs_address)
      REG_STAT: avs_readdata = {30'h0, err_reg, st_reg != ST_IDLE};
      REG_TX: avs_readdata = {23'h0, is_cmd_reg, byte_reg};
      default: avs_readdata = 32'h0;
    endcase
  end

  // pin drive: status read in poll states, byte write in write states
  assign bus.chip_select_n = !(st_reg == ST_POLL || st_reg == ST_POLL_CHK || st_reg == ST_WRITE);
  assign bus.read_strobe_n = !(st_reg == ST_POLL || st_reg == ST_POLL_CHK);
  assign bus.write_strobe_n = !(st_reg == ST_WRITE);
  // byte type held through the cycle after the strobe rises, so the device sees a stable hold
  assign bus.cmd_data_select = (st_reg == ST_WRITE || st_reg == ST_WRITE_END) ? is_cmd_reg : 1'b1;
  assign bus.host_data_oe = (st_reg == ST_WRITE) || (st_reg == ST_WRITE_END);
  assign bus.host_data = byte_reg;
endmodule

// ---- lcdci_asserts.sv ----
`timescale 1ns/1ns
// watches the port between host end and device end
module lcdci_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic cmd_data_select,
  input wire logic [7:0] host_data,
  input wire logic host_data_oe,
  input wire logic [7:0] dev_data,
  input wire logic dev_data_oe
);
  logic stat_rd; // status read on the pins
  logic wr_d_reg; // strobe one cycle back
  logic ready_reg, ready_next; // ready poll seen since last byte
  logic [3:0] idle_reg, idle_next; // cycles since a strobe, saturating
  assign stat_rd = !chip_select_n && !read_strobe_n && cmd_data_select;
  // each strobe clears the poll, so one poll is owed per byte
  always_comb begin
    ready_next = ready_reg;
    idle_next = (idle_reg == 4'hf) ? idle_reg : idle_reg + 4'h1;
    if (stat_rd && dev_data_oe) begin
      ready_next = dev_data[1:0] == 2'h3;
    end
    if (!write_strobe_n && wr_d_reg) begin
      ready_next = 1'h0;
      idle_next = 4'h0;
    end
  end
  // registers only
  always_ff @(posedge clk) begin
    wr_d_reg <= srst ? 1'h1 : write_strobe_n;
    ready_reg <= srst ? 1'h0 : ready_next;
    idle_reg <= srst ? 4'hf : idle_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_stat_drv; stat_rd |-> dev_data_oe && !host_data_oe; endproperty
  a_stat_drv: assert property (p_stat_drv) else $error("status not driven");
  property p_dev_quiet; dev_data_oe |-> stat_rd; endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("device drives outside status read");
  property p_rd_wr; !read_strobe_n |-> write_strobe_n; endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("read and write strobes together");
  property p_poll_first; $fell(write_strobe_n) |-> ready_reg; endproperty
  a_poll_first: assert property (p_poll_first) else $error("byte sent without ready poll");
  property p_wr_framed; !write_strobe_n |-> !chip_select_n && host_data_oe; endproperty
  a_wr_framed: assert property (p_wr_framed) else $error("write strobe without select or data");
  property p_wr_hold; $rose(write_strobe_n) |-> $stable(cmd_data_select) && $stable(host_data); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("byte changed at strobe end");
  property p_ready_idle; stat_rd && idle_reg > 4'h6 |-> dev_data[1:0] == 2'h3; endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("idle device reports busy");
  property p_one_strobe; $fell(write_strobe_n) |=> write_strobe_n [*2]; endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("strobe longer than one byte");
endmodule

// ---- lcdci_bench.sv ----
`timescale 1ns/1ns
// avalon side drives the host end; pixel side drives the device end
module lcdci_bench
  import lcdci_pkg::*;
;
  logic clk, srst, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, lfsr_reg;
  logic font_narrow, blink_phase, pix_req, pix_due, user_glyph_only, glyph_from_rom;
  logic [7:0] text_byte, gfx_byte, char_code, pixel_out, text_stride, gfx_stride;
  logic [15:0] text_home, gfx_home;
  logic [2:0] mix_mode;
  logic [3:0] display_enable;
  logic [55:0] cfg_now, cfg_prev, m_cfg; // settings snapshot and model
  logic [55:0] cfg_q[$]; // expected settings, oldest first
  logic [63:0] rd_q[$]; // read mask and value
  logic [8:0] pix_q[$]; // glyph flag and pixel
  logic [63:0] rd_e;
  logic [2:0] mixes [4] = '{MIX_OR, MIX_XOR, MIX_AND, MIX_ATTR};
  int error_cnt, compares, cycles;
  lcdci_if bus_i();
  lcdci_host lcdci_host_inst (.clk(clk), .srst(srst), .bus(bus_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  lcdci_device lcdci_device_inst (.clk(clk), .srst(srst), .bus(bus_i), .font_narrow(font_narrow),
    .text_byte(text_byte), .gfx_byte(gfx_byte), .char_code(char_code), .blink_phase(blink_phase),
    .text_home(text_home), .gfx_home(gfx_home), .text_stride(text_stride), .gfx_stride(gfx_stride),
    .mix_mode(mix_mode), .user_glyph_only(user_glyph_only), .display_enable(display_enable),
    .pixel_out(pixel_out), .glyph_from_rom(glyph_from_rom));
  lcdci_asserts lcdci_asserts_inst (.clk(clk), .srst(srst), .chip_select_n(bus_i.chip_select_n),
    .read_strobe_n(bus_i.read_strobe_n), .write_strobe_n(bus_i.write_strobe_n),
    .cmd_data_select(bus_i.cmd_data_select), .host_data(bus_i.host_data),
    .host_data_oe(bus_i.host_data_oe), .dev_data(bus_i.dev_data), .dev_data_oe(bus_i.dev_data_oe));
  assign cfg_now = {text_home, gfx_home, text_stride, gfx_stride, mix_mode, user_glyph_only, display_enable};
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (cfg_q.size() + rd_q.size() + pix_q.size() != 0) error_cnt++;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hold the request until waitrequest is seen low, then let an edge pass
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'h0);
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk);
  endtask
  // parameters first, model updated before the command byte goes out
  task automatic send(input logic [7:0] op, input logic [7:0] p0, input logic [7:0] p1, input int np);
    logic [55:0] old;
    old = m_cfg;
    if (np > 0) av_xfer(1'h1, REG_TX, {24'h0, p0});
    if (np > 1) av_xfer(1'h1, REG_TX, {24'h0, p1});
    if (op == CMD_TEXT_HOME) m_cfg[55:40] = {p1, p0};
    if (op == CMD_GFX_HOME) m_cfg[39:24] = {p1, p0};
    if (op == CMD_TEXT_STRIDE) m_cfg[23:16] = p0;
    if (op == CMD_GFX_STRIDE) m_cfg[15:8] = p0;
    if (op[7:4] == GRP_MODE) m_cfg[7:4] = {op[2:0], op[GLYPH_SRC_BIT]};
    if (op[7:4] == GRP_DISPLAY) m_cfg[3:0] = op[3:0];
    if (m_cfg !== old) cfg_q.push_back(m_cfg);
    av_xfer(1'h1, REG_TX, {23'h0, 1'h1, op});
  endtask
  // random pixel bytes; blink phase is driven here too, so blink is modelled
  task automatic pix_run(input logic narrow);
    logic [7:0] t, g, e;
    // the command byte lands a few cycles after the bus write; wait for it
    while (cfg_now !== m_cfg) @(posedge clk);
    repeat (4) begin
      lfsr_reg = lfsr(lfsr_reg);
      t = lfsr_reg[7:0];
      g = lfsr_reg[15:8];
      case (m_cfg[7:5])
        MIX_XOR: e = t ^ g;
        MIX_AND: e = t & g;
        MIX_ATTR: e = (g[ATTR_INHIBIT_BIT] || (g[ATTR_BLINK_BIT] && lfsr_reg[24])) ? 8'h00 : (g[ATTR_REV_BIT] ? ~t : t);
        default: e = t | g;
      endcase
      pix_q.push_back({!m_cfg[4] && lfsr_reg[23:16] < USER_CODE_BASE, narrow ? e & 8'h3f : e});
      text_byte <= t;
      gfx_byte <= g;
      char_code <= lfsr_reg[23:16];
      blink_phase <= lfsr_reg[24];
      font_narrow <= narrow;
      pix_req <= 1'h1;
      @(posedge clk);
    end
    pix_req <= 1'h0;
  endtask
  // watcher: takes the oldest note whenever a result shows
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      error_cnt++;
      summarize();
    end else begin
      if (!srst && cfg_now !== cfg_prev) chk(cfg_now, cfg_q.size() ? cfg_q.pop_front() : cfg_prev);
      cfg_prev <= cfg_now;
      if (avs_read && !avs_waitrequest && rd_q.size()) begin
        rd_e = rd_q.pop_front();
        chk(avs_readdata & rd_e[63:32], rd_e[31:0]);
      end
      if (pix_due) chk({glyph_from_rom, pixel_out}, pix_q.pop_front());
      pix_due <= pix_req;
    end
  end
  initial begin
    srst = 1'h1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {font_narrow, text_byte, gfx_byte, char_code, blink_phase, pix_req} = '0;
    error_cnt = 0;
    compares = 0;
    cycles = 0;
    m_cfg = '0;
    lfsr_reg = 32'h000158e9;
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    chk(cfg_now, {HOME_RST, HOME_RST, STRIDE_RST, STRIDE_RST, 8'h00});
    rd_q.push_back({32'h1, 32'h0});
    av_xfer(1'h0, REG_STAT, 32'h0);
    rd_q.push_back({32'hffffffff, 32'h0});
    av_xfer(1'h0, 4'hf, 32'h0);
    // stray write sets the error flag, the control word clears it
    av_xfer(1'h1, 4'hf, 32'h0);
    rd_q.push_back({32'h3, 32'h2});
    av_xfer(1'h0, REG_STAT, 32'h0);
    av_xfer(1'h1, REG_CTRL, 32'h2);
    rd_q.push_back({32'h3, 32'h0});
    av_xfer(1'h0, REG_STAT, 32'h0);
    for (int i = 0; i < 3; i++) begin
      lfsr_reg = lfsr(lfsr_reg);
      send(CMD_TEXT_HOME, lfsr_reg[7:0], lfsr_reg[15:8], 2);
      rd_q.push_back({32'h1, 32'h1});
      av_xfer(1'h0, REG_STAT, 32'h0);
      send(CMD_GFX_HOME, lfsr_reg[23:16], lfsr_reg[31:24], 2);
      send(CMD_TEXT_STRIDE, lfsr_reg[15:8], 8'h00, 1);
      send(CMD_GFX_STRIDE, lfsr_reg[7:0], 8'h00, 1);
    end
    for (int i = 0; i < 17; i++) send({GRP_DISPLAY, i[3:0] ^ 4'hc}, 8'h00, 8'h00, 0);
    for (int i = 0; i < 8; i++) begin
      send({GRP_MODE, i[2], mixes[i[1:0]]}, 8'h00, 8'h00, 0);
      pix_run(i[0] ^ i[2]);
    end
    repeat (20) @(posedge clk);
    summarize();
  end
endmodule
